/* design/fcs_params.svh */
// constants for the flash control and security front end
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_OFF_ACCESS_SIZE 12'h000
`define FCS_OFF_STATUS      12'h004
`define FCS_OFF_READ_WAIT   12'h008
`define FCS_OFF_TRIM        12'h00C
`define FCS_OFF_SECURITY    12'h010
`define FCS_ASZ_PROG        2'h1
`define FCS_ASZ_ROM         2'h2
`define FCS_WAIT_RESET      3'h0
`define FCS_STAT_RDY_BIT    0
`define FCS_STAT_HANG_BIT   1
`define FCS_TRIM_W          10
`define FCS_TRIM_ADDR       32'h0010_0004
`define FCS_PROT_ADDR       32'h0010_0000
`define FCS_PROT_CODE       16'h0001
`define FCS_MODE_USER       2'h0
`define FCS_MODE_SERIAL     2'h1
`define FCS_BOOT_FETCH_CYC  4'h2
`endif

/* design/fcs_pkg.sv */
// types shared by the flash control and security front end
package fcs_pkg;
	typedef enum logic [1:0] {
		FCS_BOOT_TRIM = 2'h0,
		FCS_BOOT_PROT = 2'h1,
		FCS_BOOT_DONE = 2'h2
	} fcs_boot_t;
endpackage

/* design/fcs_gate_if.sv */
// carrier between the register front end and the security gate
`timescale 1ns/10ps
`default_nettype none
interface fcs_gate_if;
	logic       prot_on;
	logic [1:0] boot_mode;
	logic       allow_cmd;
	logic       allow_erase;
	logic       read_valid;
	logic       jtag_ok;
	modport ctrl (output prot_on, output boot_mode,
		input allow_cmd, input allow_erase, input read_valid, input jtag_ok);
	modport gate (input prot_on, input boot_mode,
		output allow_cmd, output allow_erase, output read_valid, output jtag_ok);
endinterface
`default_nettype wire

/* design/fcs_gate.sv */
// access permission decode for the flash security gate
`timescale 1ns/10ps
`default_nettype none
`include "fcs_params.svh"
module fcs_gate (
	fcs_gate_if.gate g
);
	// permissions follow protection and the latched boot mode
	always_comb begin
		g.allow_erase = 1'b1;
		g.allow_cmd   = 1'b1;
		g.read_valid  = 1'b1;
		g.jtag_ok     = !g.prot_on;
		// R17: user mode keeps CPU access open, JTAG blocked when protected
		if (g.prot_on && g.boot_mode == `FCS_MODE_SERIAL) begin
			// R18: serial mode erase only
			g.allow_cmd  = 1'b0;
			g.read_valid = 1'b0;
		end
	end
endmodule // fcs_gate
`default_nettype wire

/* design/fcs_ctrl.sv */
// flash control registers, boot loading and security top
//
// Notes on behaviour
// R1: reset loads ROM read mode
// R2: size code 01 program, 10 ROM
// R3: master writes half-words in program mode
// R4: master dummy-reads size after change
// R5: master changes size from outside flash
// R6: hang flag bit 1, set on timeout
// R7: master issues reset command on hang
// R8: ready flag bit 0, low while busy
// R9: master discards first status read
// R10: reserved status bits ignore writes
// R11: wait code adds 0,1,3,5,7 cycles
// R12: master dummy-reads wait after change
// R13: boot copies trim word low ten bits
// R14: trim cleared by reset after erase; code clears it on a second chip erase since reset instead
// R15: protection code arms at next reset
// R16: only chip erase plus reset unlocks
// R17: user mode protected permits CPU, blocks JTAG
// R18: serial mode protected allows erase only
// R19: protection and trim share erase unit
// R20: tools write protection code last
// R21: mode pins 01 select serial write boot
// R22: select pin chooses UART or synchronous
// R23: master dummy-reads after any command
// R24: prohibited codes keep old setting
`timescale 1ns/10ps
`default_nettype none
`include "fcs_params.svh"
module fcs_ctrl #(
	parameter int ADDR_W = 12
) (
	// clock, reset, enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clk_en,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// flash array fetch port used at boot
	output logic                   boot_rd,
	output logic [31:0]            boot_addr,
	input  wire logic [31:0]       boot_rdata,
	// embedded operation status from the sequencer
	input  wire logic              op_busy,
	input  wire logic              timing_limit_flag,
	input  wire logic              hang_clear,
	input  wire logic              chip_erased,
	// boot straps
	input  wire logic [1:0]        boot_mode_pins,
	input  wire logic              comm_select_input,
	// derived controls
	output logic                   prog_mode,
	output logic [2:0]             read_extra_wait,
	output logic                   serial_write_mode,
	output logic                   serial_uart_mode,
	output logic                   allow_cmd,
	output logic                   allow_erase,
	output logic                   read_valid,
	output logic                   jtag_ok,
	output logic                   boot_done
);
	logic [1:0]          access_size_reg;
	logic [2:0]          wait_reg;
	logic                hang_reg;
	logic                rdy_reg;
	logic [`FCS_TRIM_W-1:0] trim_reg;
	logic                prot_reg;
	logic [1:0]          mode_reg;
	logic                erased_reg;
	logic [3:0]          fetch_cnt;
	logic                comm_reg;
	fcs_pkg::fcs_boot_t  boot_state;
	logic                wr_en;
	logic                rd_en;
	fcs_gate_if          gif();

	// wait code legal when odd or zero
	function automatic logic wait_legal(input logic [2:0] c);
		wait_legal = c[0] || (c == `FCS_WAIT_RESET);
	endfunction

	// one access phase per transfer, answered after one wait state
	assign wr_en = clk_en && psel && penable && pwrite && !pready;
	assign rd_en = clk_en && psel && penable && !pwrite && !pready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (clk_en) begin
			pready  <= psel && penable && !pready;
			pslverr <= 1'b0;
			if (rd_en) begin
				unique case (paddr)
				`FCS_OFF_ACCESS_SIZE: prdata <= {30'h0, access_size_reg};
				// R10: reserved status bits read zero
				`FCS_OFF_STATUS: prdata <= {30'h0, hang_reg, rdy_reg};
				`FCS_OFF_READ_WAIT: prdata <= {29'h0, wait_reg};
				`FCS_OFF_TRIM: prdata <= {22'h0, trim_reg};
				`FCS_OFF_SECURITY: prdata <= {29'h0, mode_reg, prot_reg};
				default: begin
					prdata  <= 32'h0000_0000;
					pslverr <= 1'b1;
				end
				endcase
			end else if (wr_en) begin
				pslverr <= !(paddr == `FCS_OFF_ACCESS_SIZE ||
					paddr == `FCS_OFF_READ_WAIT ||
					paddr == `FCS_OFF_STATUS);
			end
		end
	end

	// access size register, rom mode after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// R1: start in ROM read mode
			access_size_reg <= `FCS_ASZ_ROM;
		end else if (wr_en && paddr == `FCS_OFF_ACCESS_SIZE) begin
			// R2: only codes 01 and 10 accepted
			// R24: prohibited code keeps old value
			if (pwdata[1:0] == `FCS_ASZ_PROG || pwdata[1:0] == `FCS_ASZ_ROM)
				access_size_reg <= pwdata[1:0];
		end
	end

	// wait cycle register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_reg <= `FCS_WAIT_RESET;
		end else if (wr_en && paddr == `FCS_OFF_READ_WAIT) begin
			// R11: only none or odd wait codes
			if (wait_legal(pwdata[2:0]))
				wait_reg <= pwdata[2:0];
		end
	end

	// status flags; set by the timeout wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hang_reg <= 1'b0;
			rdy_reg  <= 1'b1;
		end else if (clk_en) begin
			// R8: ready low while operation runs
			rdy_reg <= !op_busy;
			// R6: hang on timing limit
			if (timing_limit_flag)
				hang_reg <= 1'b1;
			else if (hang_clear)
				hang_reg <= 1'b0;
		end
	end

	// chip erase seen since reset; a further erase then clears the trim mirror
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			erased_reg <= 1'b0;
		else if (clk_en && chip_erased)
			erased_reg <= 1'b1;
	end

	// boot sequence: fetch trim word then protection halfword
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_state <= fcs_pkg::FCS_BOOT_TRIM;
			fetch_cnt  <= 4'h0;
			trim_reg   <= '0;
			prot_reg   <= 1'b0;
			mode_reg   <= `FCS_MODE_USER;
			comm_reg   <= 1'b0;
			boot_rd    <= 1'b0;
			boot_addr  <= 32'h0000_0000;
			boot_done  <= 1'b0;
		end else if (clk_en) begin
			unique case (boot_state)
			fcs_pkg::FCS_BOOT_TRIM: begin
				// R21: mode pins caught after reset release
				mode_reg  <= boot_mode_pins;
				// R22: select level held until start
				comm_reg  <= comm_select_input;
				boot_rd   <= 1'b1;
				boot_addr <= `FCS_TRIM_ADDR;
				fetch_cnt <= fetch_cnt + 4'h1;
				if (fetch_cnt == `FCS_BOOT_FETCH_CYC) begin
					// R13: copy low ten trim bits
					// R19: shared erase unit reads blank
					trim_reg   <= boot_rdata[`FCS_TRIM_W-1:0];
					boot_addr  <= `FCS_PROT_ADDR;
					fetch_cnt  <= 4'h0;
					boot_state <= fcs_pkg::FCS_BOOT_PROT;
				end
			end
			fcs_pkg::FCS_BOOT_PROT: begin
				fetch_cnt <= fetch_cnt + 4'h1;
				if (fetch_cnt == `FCS_BOOT_FETCH_CYC) begin
					// R15: code armed only at reset
					// R16: erased array reads unprotected
					prot_reg   <= boot_rdata[15:0] == `FCS_PROT_CODE;
					boot_rd    <= 1'b0;
					boot_done  <= 1'b1;
					boot_state <= fcs_pkg::FCS_BOOT_DONE;
				end
			end
			fcs_pkg::FCS_BOOT_DONE: begin
				// R14: erase clears trim mirror later
				if (erased_reg && chip_erased)
					trim_reg <= '0;
			end
			default: boot_state <= fcs_pkg::FCS_BOOT_DONE;
			endcase
		end
	end

	assign gif.prot_on   = prot_reg;
	assign gif.boot_mode = mode_reg;

	fcs_gate u_gate (
		.g (gif.gate)
	);

	// registered control outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_mode         <= 1'b0;
			read_extra_wait   <= `FCS_WAIT_RESET;
			serial_write_mode <= 1'b0;
			serial_uart_mode  <= 1'b0;
			allow_cmd         <= 1'b0;
			allow_erase       <= 1'b0;
			read_valid        <= 1'b0;
			jtag_ok           <= 1'b0;
		end else if (clk_en) begin
			prog_mode         <= access_size_reg == `FCS_ASZ_PROG;
			// R11: waits apply in ROM mode only
			read_extra_wait   <= (access_size_reg == `FCS_ASZ_ROM) ?
				wait_reg : `FCS_WAIT_RESET;
			// R21: serial write boot
			serial_write_mode <= boot_done && mode_reg == `FCS_MODE_SERIAL;
			serial_uart_mode  <= boot_done && comm_reg;
			// R17: gate outputs after boot only
			allow_cmd         <= boot_done && gif.allow_cmd;
			allow_erase       <= boot_done && gif.allow_erase;
			read_valid        <= boot_done && gif.read_valid;
			jtag_ok           <= boot_done && gif.jtag_ok;
		end
	end

	// R1: reset value lands in ROM mode
	a_rom_after_reset: assert property (@(posedge pclk)
		$rose(presetn) |-> access_size_reg == `FCS_ASZ_ROM) // R1
		else $error("access size not ROM after reset");

	// R2: illegal size code not stored
	a_size_legal: assert property (@(posedge pclk) disable iff (!presetn)
		access_size_reg == `FCS_ASZ_PROG || access_size_reg == `FCS_ASZ_ROM) // R2
		else $error("illegal access size stored");

	// R6: timeout sets hang next cycle
	a_hang_sets: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && timing_limit_flag |=> hang_reg) // R6
		else $error("hang flag missed timeout");

	// R8: ready mirrors busy
	a_ready_busy: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && op_busy |=> !rdy_reg) // R8
		else $error("ready high while busy");

	// R11: wait register holds legal code
	a_wait_legal: assert property (@(posedge pclk) disable iff (!presetn)
		wait_legal(wait_reg)) // R11
		else $error("illegal wait code stored");

	// R15: protection fixed after boot
	a_prot_stable: assert property (@(posedge pclk) disable iff (!presetn)
		boot_done |=> $stable(prot_reg)) // R15
		else $error("protection changed without reset");

	// R18: serial mode protected blocks commands
	sequence s_serial_locked;
		boot_done && prot_reg && mode_reg == `FCS_MODE_SERIAL && clk_en;
	endsequence
	a_serial_lock: assert property (@(posedge pclk) disable iff (!presetn)
		s_serial_locked |=> !allow_cmd && !read_valid && allow_erase) // R18
		else $error("serial mode lock not applied");

	// R17: protection blocks jtag
	a_jtag_block: assert property (@(posedge pclk) disable iff (!presetn)
		boot_done && prot_reg && clk_en |=> !jtag_ok) // R17
		else $error("jtag open while protected");

	// R13: trim copied at end of trim fetch
	a_trim_copy: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && boot_state == fcs_pkg::FCS_BOOT_TRIM &&
		fetch_cnt == `FCS_BOOT_FETCH_CYC |=>
		trim_reg == $past(boot_rdata[`FCS_TRIM_W-1:0])) // R13
		else $error("trim mirror not loaded");
endmodule // fcs_ctrl
`default_nettype wire

/* dv/fcs_flash_model.sv */
// behavioural flash array that answers the boot fetch port
`timescale 1ns/10ps
`default_nettype none
`include "fcs_params.svh"
module fcs_flash_model (
	// clock
	input  wire logic        pclk,
	// boot fetch port
	input  wire logic        boot_rd,
	input  wire logic [31:0] boot_addr,
	output logic [31:0]      boot_rdata,
	// array contents set by the bench
	input  wire logic [31:0] trim_word,
	input  wire logic [31:0] prot_word
);
	logic [31:0] a1;
	logic [31:0] junk = 32'h5A5A_A5A5;
	// address delay: data is good from the second edge after a change;
	// junk moves every cycle so an early sample never looks valid
	always_ff @(posedge pclk) begin
		a1   <= boot_addr;
		junk <= ~junk + 32'h1;
	end
	always_comb begin
		boot_rdata = junk;
		if (boot_rd && a1 == boot_addr) begin
			if (boot_addr == `FCS_TRIM_ADDR)
				boot_rdata = trim_word;
			else if (boot_addr == `FCS_PROT_ADDR)
				boot_rdata = prot_word;
		end
	end
endmodule // fcs_flash_model
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the flash control and security front end
`timescale 1ns/10ps
`default_nettype none
`include "fcs_params.svh"
module testbench;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready;
	logic        pslverr, boot_rd, op_busy, timing_limit_flag, er;
	logic        hang_clear, chip_erased, comm_select_input, prog_mode;
	logic        serial_write_mode, serial_uart_mode, allow_cmd, boot_done;
	logic        allow_erase, read_valid, jtag_ok;
	logic [1:0]  boot_mode_pins;
	logic [2:0]  read_extra_wait;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, boot_addr, boot_rdata, rd;
	logic [31:0] trim_word, prot_word;
	int          mismatches, samples_checked;

	fcs_ctrl u_fcs_ctrl (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .boot_rd(boot_rd), .boot_addr(boot_addr),
		.boot_rdata(boot_rdata), .op_busy(op_busy),
		.timing_limit_flag(timing_limit_flag), .hang_clear(hang_clear),
		.chip_erased(chip_erased), .boot_mode_pins(boot_mode_pins),
		.comm_select_input(comm_select_input), .prog_mode(prog_mode),
		.read_extra_wait(read_extra_wait),
		.serial_write_mode(serial_write_mode),
		.serial_uart_mode(serial_uart_mode), .allow_cmd(allow_cmd),
		.allow_erase(allow_erase), .read_valid(read_valid),
		.jtag_ok(jtag_ok), .boot_done(boot_done));
	fcs_flash_model u_fcs_flash_model (.pclk(pclk), .boot_rd(boot_rd),
		.boot_addr(boot_addr), .boot_rdata(boot_rdata),
		.trim_word(trim_word), .prot_word(prot_word));

	// 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input string nm, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		// whole-word transfers only, never byte writes
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			mismatches++;
			$display("unexpected pready expected 1 seen %b", pready);
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// reset with straps set, then wait for the boot fetch to finish
	task automatic boot(input logic [1:0] pins, input logic sel);
		int n;
		n = 0;
		boot_mode_pins    <= pins;
		comm_select_input <= sel;
		presetn           <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		while (boot_done !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		chk("boot_done", {31'h0, boot_done}, 32'h1);
	endtask

	function automatic logic [31:0] gates();
		return {28'h0, allow_cmd, allow_erase, read_valid, jtag_ok};
	endfunction

	task automatic t_reset();
		boot(2'h0, 1'b0);
		apb(1'b0, `FCS_OFF_ACCESS_SIZE, 32'h0);
		chk("access_size", rd, 32'h2);
		chk("prog_mode", {31'h0, prog_mode}, 32'h0);
		apb(1'b0, `FCS_OFF_STATUS, 32'h0);
		chk("status", rd, 32'h1);
		apb(1'b0, `FCS_OFF_READ_WAIT, 32'h0);
		chk("wait_reset", rd, 32'h0);
		apb(1'b1, `FCS_OFF_TRIM, 32'h0);
		chk("trim_wr_err", {31'h0, er}, 32'h1);
		apb(1'b0, `FCS_OFF_TRIM, 32'h0);
		chk("trim", rd, {22'h0, trim_word[9:0]});
		apb(1'b0, `FCS_OFF_SECURITY, 32'h0);
		chk("unprotected", rd, 32'h0);
		chk("gates_open", gates(), 32'hF);
		apb(1'b0, 12'h0FC, 32'h0);
		chk("unmapped_err", {31'h0, er}, 32'h1);
		$display("test reset and boot done");
	endtask

	task automatic t_size();
		logic [1:0] cur;
		logic [1:0] code;
		cur = 2'h2;
		for (int c = 0; c < 4; c++) begin
			code = 2'(c ^ 1);
			apb(1'b1, `FCS_OFF_ACCESS_SIZE, {30'h0, code});
			if (code == 2'h1 || code == 2'h2)
				cur = code;
			// bench-side write, then a checked read back
			apb(1'b0, `FCS_OFF_ACCESS_SIZE, 32'h0);
			chk("size_field", rd, {30'h0, cur});
			chk("prog_mode", {31'h0, prog_mode}, {31'h0, cur == 2'h1});
		end
		$display("test access size done");
	endtask

	task automatic t_wait();
		logic [2:0] cur;
		cur = 3'h0;
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, `FCS_OFF_READ_WAIT, 32'(c));
			if (c == 0 || c[0])
				cur = 3'(c);
			apb(1'b0, `FCS_OFF_READ_WAIT, 32'h0);
			chk("wait_field", rd, {29'h0, cur});
			chk("extra_wait", {29'h0, read_extra_wait}, {29'h0, cur});
		end
		$display("test wait cycles done");
	endtask

	task automatic t_status();
		op_busy <= 1'b1;
		apb(1'b0, `FCS_OFF_STATUS, 32'h0);
		chk("busy", rd, 32'h0);
		// a frozen clock enable must swallow the timeout
		op_busy           <= 1'b0;
		clk_en            <= 1'b0;
		timing_limit_flag <= 1'b1;
		@(posedge pclk);
		clk_en            <= 1'b1;
		timing_limit_flag <= 1'b0;
		apb(1'b0, `FCS_OFF_STATUS, 32'h0);
		chk("frozen", rd, 32'h1);
		timing_limit_flag <= 1'b1;
		@(posedge pclk);
		timing_limit_flag <= 1'b0;
		apb(1'b1, `FCS_OFF_STATUS, 32'h0);
		chk("status_wr_err", {31'h0, er}, 32'h0);
		apb(1'b0, `FCS_OFF_STATUS, 32'h0);
		chk("hang", rd, 32'h3);
		// reset command completion clears the hang
		hang_clear <= 1'b1;
		@(posedge pclk);
		hang_clear <= 1'b0;
		apb(1'b0, `FCS_OFF_STATUS, 32'h0); // dummy read discarded
		apb(1'b0, `FCS_OFF_STATUS, 32'h0);
		chk("hang_cleared", rd, 32'h1);
		// timeout and clear in one cycle: the set wins
		timing_limit_flag <= 1'b1;
		hang_clear        <= 1'b1;
		@(posedge pclk);
		timing_limit_flag <= 1'b0;
		hang_clear        <= 1'b0;
		apb(1'b0, `FCS_OFF_STATUS, 32'h0);
		chk("hang_set_wins", rd, 32'h3);
		$display("test status done");
	endtask

	task automatic t_secure();
		// protection code stored as the final step
		prot_word <= 32'hFFFF_0001;
		boot(2'h0, 1'b0);
		apb(1'b0, `FCS_OFF_SECURITY, 32'h0);
		chk("prot_user", rd, 32'h1);
		chk("gates_user", gates(), 32'hE);
		boot(2'h1, 1'b1);
		apb(1'b0, `FCS_OFF_SECURITY, 32'h0);
		chk("prot_serial", rd, 32'h3);
		chk("gates_serial", gates(), 32'h4);
		chk("serial_boot", {31'h0, serial_write_mode}, 32'h1);
		chk("uart", {31'h0, serial_uart_mode}, 32'h1);
		boot(2'h1, 1'b0);
		// mode outputs follow boot_done by one edge
		@(posedge pclk);
		chk("sync", {31'h0, serial_uart_mode}, 32'h0);
		$display("test security done");
	endtask

	task automatic t_erase();
		chip_erased <= 1'b1;
		@(posedge pclk);
		chip_erased <= 1'b0;
		trim_word   <= 32'hFFFF_FFFF;
		prot_word   <= 32'hFFFF_FFFF;
		apb(1'b0, `FCS_OFF_SECURITY, 32'h0);
		chk("prot_kept", rd, 32'h3);
		boot(2'h1, 1'b0);
		apb(1'b0, `FCS_OFF_SECURITY, 32'h0);
		chk("prot_erased", rd, 32'h2);
		chk("gates_erased", gates(), 32'hF);
		apb(1'b0, `FCS_OFF_TRIM, 32'h0);
		chk("trim_blank", rd, 32'h0000_03FF);
		// an erase held for two cycles marks erased_reg, then drops the mirror
		chip_erased <= 1'b1;
		repeat (2) @(posedge pclk);
		chip_erased <= 1'b0;
		apb(1'b0, `FCS_OFF_TRIM, 32'h0);
		chk("trim_cleared", rd, 32'h0);
		$display("test chip erase done");
	endtask

	// hang guard well beyond the few hundred cycles the tests take
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		conclude();
	end

	initial begin
		{presetn, psel, penable, pwrite, op_busy} = 5'h0;
		{timing_limit_flag, hang_clear, chip_erased} = 3'h0;
		clk_en            = 1'b1;
		comm_select_input = 1'b0;
		boot_mode_pins    = 2'h0;
		paddr             = 12'h0;
		pwdata            = 32'h0;
		trim_word         = 32'hFFFF_F2A5;
		prot_word         = 32'hFFFF_FFFF;
		t_reset();
		t_size();
		t_wait();
		t_status();
		t_secure();
		t_erase();
		conclude();
	end
endmodule // testbench
`default_nettype wire
